// ===== core/serial_adc_reader_params.svh
// constants for the serial converter reader: widths, timing counts, pin levels
// assumes the reader runs on a 10 MHz system clock and a 12.5 MHz link clock
//
// Function
// (R1) While no read runs, every converter select line is held high.
// (R2) A read first parks the converter clock low before any select goes low.
// (R3) The chosen converter is enabled by pulling its select low for the whole read.
// (R4) After selection one clock pulse starts the conversion before any bit is taken.
// (R5) Each of 8 bits is clocked, sampled and shifted in from the bottom, MSB first.
// (R6) After the last bit the select returns high and the byte becomes the result.
// (R7) The converter returns 255 at its upper reference and zero at its lower one.
// (R8) With several converters on shared lines only the addressed select is asserted.
// (R9) In automatic mode a complete read is repeated once every 2 seconds.
// (R10) A start is taken only when idle; completion gives a one-cycle done pulse
//       and a result that holds until the next read ends.
// (R11) Each converter clock phase lasts a configurable number of link clock cycles.
`ifndef SERIAL_ADC_READER_PARAMS_SVH
`define SERIAL_ADC_READER_PARAMS_SVH

`define ADC_BITS        8
`define ADC_FULL_SCALE  8'hFF
`define ADC_ZERO_SCALE  8'h00
`define ADC_NUM_DEFAULT 4

// select pins are active low; the idle level is high
`define SEL_IDLE_LEVEL  1'b1
`define CLK_PARK_LEVEL  1'b0

// automatic read period on the system clock
`define MCLK_HZ         10000000
`define READ_PERIOD_MS  2000
`define READ_PERIOD_CYC (`READ_PERIOD_MS * (`MCLK_HZ / 1000))

// converter clock phase width on the link clock, rounded up
`define CLK_PHASE_NS    10000
`define LINK_CLK_NS     80
`define CLK_PHASE_CYC   ((`CLK_PHASE_NS + `LINK_CLK_NS - 1) / `LINK_CLK_NS)

`endif

// ===== core/serial_adc_reader_pkg.sv
// types shared by the serial converter reader
// assumes nothing beyond a SystemVerilog elaborator
package serial_adc_reader_pkg;

  // request side, on the system clock
  typedef enum logic [0:0] {
    S_IDLE = 1'b0,
    S_WAIT = 1'b1
  } sys_state_t;

  // pin side, on the link clock
  typedef enum logic [2:0] {
    L_IDLE = 3'h0,
    L_PARK = 3'h1,
    L_SEL  = 3'h2,
    L_STHI = 3'h3,
    L_STLO = 3'h4,
    L_BHI  = 3'h5,
    L_BLO  = 3'h6
  } link_state_t;

endpackage

// ===== core/sync_2ff.sv
// two flip-flop synchroniser for levels and toggles
// assumes the input is either quasi-static or changes at most once per handshake
`timescale 1ns/1ps
module sync_2ff #(
  parameter int   WIDTH = 1,
  parameter logic RST   = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= {WIDTH{RST}};
      dout <= {WIDTH{RST}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ===== core/period_timer.sv
// free-running divider giving one tick pulse every COUNT cycles while run is high
// assumes run comes from logic on the same clock
`timescale 1ns/1ps
module period_timer #(
  parameter int COUNT = 20000000
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);

  localparam int W = (COUNT > 1) ? $clog2(COUNT) : 1;
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tick;

  // a count below two would tick every cycle and flood the requester
  if (COUNT < 2) begin : g_chk
    $error("period_timer: COUNT must be at least 2");
  end

  // stopping restarts the full period, so the first read after enabling
  // comes one whole period later
  always_comb begin
    next_cnt  = '0;
    next_tick = 1'b0;
    if (run) begin
      next_cnt  = (cnt == LAST) ? '0 : cnt + W'(1);
      next_tick = (cnt == LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule

// ===== core/serial_adc_reader.sv
// reader for one or more three-wire serial 8-bit converters on shared clock/data
// assumes convData arrives from a pin, linkClk is unrelated to mclk, and
// startReq, autoRun and adcSel come from logic on mclk
`timescale 1ns/1ps
`include "serial_adc_reader_params.svh"
module serial_adc_reader
  import serial_adc_reader_pkg::*;
#(
  parameter int NUM_ADC      = `ADC_NUM_DEFAULT,
  parameter int PERIOD_CYC   = `READ_PERIOD_CYC,
  parameter int PHASE_CYC    = `CLK_PHASE_CYC,
  parameter int IDX_W        = (NUM_ADC > 1) ? $clog2(NUM_ADC) : 1
) (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic               linkClk,
  input  wire logic               startReq,
  input  wire logic               autoRun,
  input  wire logic [IDX_W-1:0]   adcSel,
  input  wire logic               convData,
  output logic                    convClk,
  output logic      [NUM_ADC-1:0] convSelN,
  output logic                    busy,
  output logic                    done,
  output logic      [`ADC_BITS-1:0] result
);

  localparam int CW = $clog2(PHASE_CYC + 1);
  localparam logic [CW-1:0] RELOAD = CW'(PHASE_CYC - 1);
  localparam logic [NUM_ADC-1:0] ONE = NUM_ADC'(1);
  localparam logic [2:0] LAST_BIT = 3'(`ADC_BITS - 1);

  // the data pin passes two link flops, so a phase shorter than three
  // cycles would sample a bit that has not yet reached the shifter
  if (PHASE_CYC < 3) begin : g_chk_phase
    $error("serial_adc_reader: PHASE_CYC must be at least 3");
  end
  if (NUM_ADC < 1 || (1 << IDX_W) < NUM_ADC) begin : g_chk_num
    $error("serial_adc_reader: NUM_ADC does not fit the select index");
  end
  if (`ADC_BITS != 8) begin : g_chk_bits
    $error("serial_adc_reader: bit counter is sized for 8 bits");
  end

  ////////////////////////////////////////////////////////////////////////////
  // crossings

  logic                 linkRstn;
  logic                 reqTgl;
  logic                 reqSync;
  logic                 doneTgl;
  logic                 doneSync;
  logic                 dataSync;
  logic [`ADC_BITS-1:0] linkResult;
  logic [IDX_W-1:0]     selLatch;

  // reset reaches the link logic through two link flops
  sync_2ff #(.WIDTH(1), .RST(1'b0)) u_rst_sync (
    .clk  (linkClk),
    .rstn (1'b1),
    .din  (rstn),
    .dout (linkRstn)
  );

  // start event travels as a toggle; selLatch is held stable meanwhile
  sync_2ff #(.WIDTH(1), .RST(1'b0)) u_req_sync (
    .clk  (linkClk),
    .rstn (linkRstn),
    .din  (reqTgl),
    .dout (reqSync)
  );

  // completion event travels back as a toggle; linkResult stays put
  sync_2ff #(.WIDTH(1), .RST(1'b0)) u_done_sync (
    .clk  (mclk),
    .rstn (rstn),
    .din  (doneTgl),
    .dout (doneSync)
  );

  // serial data pin into the link domain
  sync_2ff #(.WIDTH(1), .RST(1'b0)) u_data_sync (
    .clk  (linkClk),
    .rstn (linkRstn),
    .din  (convData),
    .dout (dataSync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // periodic trigger

  logic periodTick;

  period_timer #(.COUNT(PERIOD_CYC)) u_period (
    .clk  (mclk),
    .rstn (rstn),
    .run  (autoRun),
    .tick (periodTick)  // see (R9)
  );

  ////////////////////////////////////////////////////////////////////////////
  // request side on mclk

  sys_state_t           sState;
  sys_state_t           next_sState;
  logic                 doneSeen;
  logic                 next_doneSeen;
  logic                 next_reqTgl;
  logic [IDX_W-1:0]     next_selLatch;
  logic                 next_busy;
  logic                 next_done;
  logic [`ADC_BITS-1:0] next_result;

  // starts arriving while a read runs are dropped, not queued
  always_comb begin
    next_sState   = sState;
    next_doneSeen = doneSeen;
    next_reqTgl   = reqTgl;
    next_selLatch = selLatch;
    next_busy     = busy;
    next_done     = 1'b0;
    next_result   = result;
    unique case (sState)
      S_IDLE: begin
        if (startReq || periodTick) begin  // see (R10) see (R9)
          next_reqTgl   = ~reqTgl;
          next_selLatch = adcSel;
          next_busy     = 1'b1;
          next_sState   = S_WAIT;
        end
      end
      S_WAIT: begin
        if (doneSync != doneSeen) begin
          next_doneSeen = doneSync;
          next_result   = linkResult;  // see (R6) see (R10)
          next_done     = 1'b1;
          next_busy     = 1'b0;
          next_sState   = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sState   <= S_IDLE;
      doneSeen <= 1'b0;
      reqTgl   <= 1'b0;
      selLatch <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
      result   <= `ADC_ZERO_SCALE;
    end else begin
      sState   <= next_sState;
      doneSeen <= next_doneSeen;
      reqTgl   <= next_reqTgl;
      selLatch <= next_selLatch;
      busy     <= next_busy;
      done     <= next_done;
      result   <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin side on linkClk

  link_state_t          lState;
  link_state_t          next_lState;
  logic [CW-1:0]        cnt;
  logic [CW-1:0]        next_cnt;
  logic [2:0]           bitCnt;
  logic [2:0]           next_bitCnt;
  logic [`ADC_BITS-1:0] shift;
  logic [`ADC_BITS-1:0] next_shift;
  logic [`ADC_BITS-1:0] next_linkResult;
  logic                 next_convClk;
  logic [NUM_ADC-1:0]   next_convSelN;
  logic                 next_doneTgl;
  logic                 reqSeen;
  logic                 next_reqSeen;
  logic                 phaseEnd;
  logic [`ADC_BITS-1:0] shifted;

  assign phaseEnd = (cnt == '0);
  assign shifted  = {shift[`ADC_BITS-2:0], dataSync};  // see (R5)

  // every phase, parked or pulsing, lasts PHASE_CYC link cycles
  always_comb begin
    next_lState     = lState;
    next_cnt        = phaseEnd ? RELOAD : cnt - CW'(1);  // see (R11)
    next_bitCnt     = bitCnt;
    next_shift      = shift;
    next_linkResult = linkResult;
    next_convClk    = convClk;
    next_convSelN   = convSelN;
    next_doneTgl    = doneTgl;
    next_reqSeen    = reqSeen;
    unique case (lState)
      L_IDLE: begin
        next_cnt      = RELOAD;
        next_convSelN = {NUM_ADC{`SEL_IDLE_LEVEL}};  // see (R1)
        if (reqSync != reqSeen) begin
          next_reqSeen = reqSync;
          next_convClk = `CLK_PARK_LEVEL;  // see (R2)
          next_lState  = L_PARK;
        end
      end
      L_PARK: begin
        if (phaseEnd) begin
          // only the addressed select drops; the rest stay high
          next_convSelN = ~(ONE << selLatch);  // see (R3) see (R8)
          next_lState   = L_SEL;
        end
      end
      L_SEL: begin
        if (phaseEnd) begin
          next_convClk = 1'b1;  // see (R4)
          next_lState  = L_STHI;
        end
      end
      L_STHI: begin
        if (phaseEnd) begin
          next_convClk = 1'b0;
          next_lState  = L_STLO;
        end
      end
      L_STLO: begin
        if (phaseEnd) begin
          next_convClk = 1'b1;
          next_bitCnt  = '0;
          next_shift   = '0;
          next_lState  = L_BHI;
        end
      end
      L_BHI: begin
        if (phaseEnd) begin
          next_convClk = 1'b0;
          next_lState  = L_BLO;
        end
      end
      L_BLO: begin
        // sample at the end of the low phase, once the bit has settled
        if (phaseEnd) begin
          next_shift = shifted;  // see (R5)
          if (bitCnt == LAST_BIT) begin
            next_convSelN   = {NUM_ADC{`SEL_IDLE_LEVEL}};  // see (R6)
            next_linkResult = shifted;
            next_doneTgl    = ~doneTgl;
            next_lState     = L_IDLE;
          end else begin
            next_bitCnt  = bitCnt + 3'(1);
            next_convClk = 1'b1;
            next_lState  = L_BHI;
          end
        end
      end
      default: begin
        next_convSelN = {NUM_ADC{`SEL_IDLE_LEVEL}};
        next_convClk  = `CLK_PARK_LEVEL;
        next_lState   = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge linkClk) begin
    if (!linkRstn) begin
      lState     <= L_IDLE;
      cnt        <= RELOAD;
      bitCnt     <= '0;
      shift      <= '0;
      linkResult <= `ADC_ZERO_SCALE;
      convClk    <= `CLK_PARK_LEVEL;
      convSelN   <= {NUM_ADC{`SEL_IDLE_LEVEL}};  // see (R1)
      doneTgl    <= 1'b0;
      reqSeen    <= 1'b0;
    end else begin
      lState     <= next_lState;
      cnt        <= next_cnt;
      bitCnt     <= next_bitCnt;
      shift      <= next_shift;
      linkResult <= next_linkResult;
      convClk    <= next_convClk;
      convSelN   <= next_convSelN;
      doneTgl    <= next_doneTgl;
      reqSeen    <= next_reqSeen;
    end
  end

endmodule

// ===== tb/adc_model.sv
// behavioural model of an 8-bit three-wire serial converter bank on shared clock/data
// assumes codes holds one byte per select, converter 0 in the low byte
`timescale 1ns/1ps
module adc_model (
  input  wire logic        convClk,
  input  wire logic [3:0]  convSelN,
  input  wire logic [31:0] codes,
  output logic             convData
);
  int         cnt;
  logic [7:0] sh;
  initial begin
    convData = 1'b0;
    cnt = 0;
    sh = 8'h00;
  end
  // no pull on the data line: a released line shows the inverse of its last bit
  always @(convSelN) begin
    if (&convSelN) begin
      cnt = 0;
      convData = ~convData;
    end
  end
  // start pulse latches the code, later falling edges shift it out msb first
  always @(negedge convClk) begin
    if (!(&convSelN)) begin
      cnt = cnt + 1;
      for (int i = 0; i < 4; i++) begin
        if (cnt == 1 && !convSelN[i]) sh = codes[8*i +: 8];
      end
      if (cnt >= 2) begin
        convData = sh[7];
        sh = {sh[6:0], 1'b0};
      end
    end
  end
endmodule

// ===== tb/serial_adc_reader_sva.sv
// checker for the converter reader pins and request handshake
// assumes it is bound into each serial_adc_reader and sees only its ports
`timescale 1ns/1ps
module serial_adc_reader_sva #(
  parameter int NUM_ADC   = 4,
  parameter int PHASE_CYC = 125,
  parameter int IDX_W     = 2
) (
  input wire logic               mclk,
  input wire logic               rstn,
  input wire logic               linkClk,
  input wire logic               startReq,
  input wire logic               autoRun,
  input wire logic [IDX_W-1:0]   adcSel,
  input wire logic               convData,
  input wire logic               convClk,
  input wire logic [NUM_ADC-1:0] convSelN,
  input wire logic               busy,
  input wire logic               done,
  input wire logic [7:0]         result
);
  int   hiCnt;
  int   loCnt;
  int   riseCnt;
  logic prevClk;
  logic rstnLinkMeta = 1'b0;
  logic rstnLink     = 1'b0;
  // link-side properties wait until reset has reached the link clock, as the design does
  always @(posedge linkClk) begin
    rstnLinkMeta <= rstn;
    rstnLink     <= rstnLinkMeta;
  end
  ////////////////////////////////////////////////////////////
  // phase and pulse counters; idle pins during reset clear them, so no reset term
  always_ff @(posedge linkClk) begin
    hiCnt   <= convClk ? hiCnt + 1 : 0;
    loCnt   <= (!convClk && !(&convSelN)) ? loCnt + 1 : 0;
    riseCnt <= (&convSelN) ? 0 : riseCnt + int'(convClk && !prevClk);
    prevClk <= convClk;
  end
  idle_sel_high_a: assert property (@(posedge mclk) disable iff (!rstn)
    !busy |-> &convSelN) else $error("select low while idle");
  park_first_a: assert property (@(posedge linkClk) disable iff (!rstnLink)
    (!(&convSelN) && $past(&convSelN)) |-> !convClk && !$past(convClk))
    else $error("clock not parked at select");
  clk_needs_sel_a: assert property (@(posedge linkClk) disable iff (!rstnLink)
    convClk |-> !(&convSelN)) else $error("clock pulse without select");
  one_select_a: assert property (@(posedge linkClk) disable iff (!rstnLink)
    $onehot0(~convSelN)) else $error("more than one select low");
  high_width_a: assert property (@(posedge linkClk) disable iff (!rstnLink)
    (prevClk && !convClk) |-> hiCnt == PHASE_CYC) else $error("clock high width");
  low_width_a: assert property (@(posedge linkClk) disable iff (!rstnLink)
    (convClk && !prevClk) |-> loCnt == PHASE_CYC) else $error("clock low width");
  pulse_count_a: assert property (@(posedge linkClk) disable iff (!rstnLink)
    (&convSelN && !$past(&convSelN)) |-> riseCnt == 9 && !convClk)
    else $error("pulses per read");
  done_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
    done |=> !done) else $error("done longer than one cycle");
  done_ends_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
    done |-> !busy && $past(busy) && &convSelN) else $error("done without read");
  start_taken_a: assert property (@(posedge mclk) disable iff (!rstn)
    (startReq && !busy) |=> busy) else $error("start not taken");
  result_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    !done |-> $stable(result)) else $error("result moved without done");
endmodule
bind serial_adc_reader serial_adc_reader_sva #(
  .NUM_ADC(NUM_ADC), .PHASE_CYC(PHASE_CYC), .IDX_W(IDX_W)
) u_sva (
  .mclk(mclk), .rstn(rstn), .linkClk(linkClk), .startReq(startReq), .autoRun(autoRun),
  .adcSel(adcSel), .convData(convData), .convClk(convClk), .convSelN(convSelN),
  .busy(busy), .done(done), .result(result)
);

// ===== tb/tb_serial_adc_reader.sv
// self-checking bench for the converter reader with a four-converter bank model
// assumes phase width 4 link cycles and a shortened automatic period
`timescale 1ns/1ps
module tb_serial_adc_reader;
  import serial_adc_reader_pkg::*;
  localparam int PER = 500;
  logic        mclk, linkClk, rstn, startReq, autoRun, convData, convClk, busy, done;
  logic [1:0]  adcSel;
  logic [3:0]  convSelN, seen;
  logic [7:0]  result;
  logic [31:0] codes;
  int          error_cnt, samples_checked, cyc, n;
  serial_adc_reader #(.NUM_ADC(4), .PERIOD_CYC(PER), .PHASE_CYC(4)) u_dut (
    .mclk(mclk), .rstn(rstn), .linkClk(linkClk), .startReq(startReq), .autoRun(autoRun),
    .adcSel(adcSel), .convData(convData), .convClk(convClk), .convSelN(convSelN),
    .busy(busy), .done(done), .result(result));
  adc_model u_adc (.convClk(convClk), .convSelN(convSelN), .codes(codes), .convData(convData));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // link clock offset so its edges never line up with mclk
  initial begin
    linkClk = 1'b0;
    #13;
    forever #40 linkClk = ~linkClk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard: a full run needs well under this many cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // one read; a second start is poked at cycle poke to show it is ignored
  task automatic do_read(logic [1:0] idx, int poke);
    @(posedge mclk);
    adcSel <= idx;
    startReq <= 1'b1;
    n = 0;
    seen = 4'h0;
    do begin
      @(posedge mclk);
      startReq <= (n == poke);
      if (n == poke) adcSel <= 2'h3;
      #1;
      seen = seen | ~convSelN;
      n++;
    end while (done !== 1'b1 && n < 3000);
    check("done seen", 8'h01, {7'h0, done});
  endtask
  task automatic t_reset();
    check("idle selects", 8'h0F, {4'h0, convSelN});
    check("parked clock", 8'h00, {7'h0, convClk});
    check("reset result", 8'h00, result);
    $display("test reset done");
  endtask
  // back-to-back reads of every converter, codes include zero and full scale
  task automatic t_sweep();
    for (int i = 0; i < 4; i++) begin
      do_read(i[1:0], -1);
      check("result", codes[8*i +: 8], result);
      check("selects used", {4'h0, 4'h1 << i}, {4'h0, seen});
      check("released", 8'h0F, {4'h0, convSelN});
    end
    $display("test sweep done");
  endtask
  task automatic t_refuse();
    do_read(2'h1, 10);
    check("first result", codes[15:8], result);
    check("no retarget", 8'h02, {4'h0, seen});
    repeat (30) @(posedge mclk);
    #1;
    check("no queued read", 8'h00, {7'h0, busy});
    $display("test refuse done");
  endtask
  task automatic t_auto();
    @(posedge mclk);
    adcSel <= 2'h3;
    autoRun <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge mclk);
        #1;
        n++;
      end while (done !== 1'b1 && n < PER + 500);
      check("auto gap", 8'h01, {7'h0, n > PER - 10 && n < PER + 300});
      check("auto result", codes[31:24], result);
    end
    @(posedge mclk);
    autoRun <= 1'b0;
    $display("test auto done");
  endtask
  initial begin
    rstn = 1'b0;
    startReq = 1'b0;
    autoRun = 1'b0;
    adcSel = 2'h0;
    codes = 32'hA5FF003C;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    repeat (5) @(posedge mclk);
    t_reset();
    t_sweep();
    t_refuse();
    t_auto();
    complete_run();
  end
endmodule
